/* bench/output_test_pattern_regs_tb.sv */
// Purpose: Self-checking bench for the test pattern bank
// Assumes: Serial bit time of ten core cycles
// Notes: Registers reached only over the serial port
module output_test_pattern_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tp_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic cs_n = 1'b1;
  logic sck = 1'b0;
  logic sdi = 1'b0;
  logic [11:0] cda = 12'h000;
  logic [11:0] cdb = 12'h000;
  logic cv = 1'b0;
  logic sdo_out, sdo_oe, out_valid, pattern_enable;
  out_word_t owa, owb;
  int err_count = 0;
  int n_tests = 0;
  logic [7:0] rd;
  logic [7:0] hi [2] = '{8'hff, 8'h95};
  logic [7:0] lo [2] = '{8'hb6, 8'h49};
  always #10 core_clk = ~core_clk;
  output_test_pattern_regs u_dut (.core_clk(core_clk), .resetn(resetn), .ce(ce),
    .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .conv_data_a(cda), .conv_data_b(cdb), .conv_valid(cv), .out_word_a(owa),
    .out_word_b(owb), .out_valid(out_valid), .pattern_enable(pattern_enable));
  // =====
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Frame of flag, address, data; phases kept well above the oversampling limit
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] w;
    w = {rw, a, d};
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = w[i];
      cyc(5);
      if (i < 8) rd[i] = sdo_out;
      sck = 1'b1;
      cyc(5);
      sck = 1'b0;
    end
    cyc(2);
    cs_n = 1'b1;
    cyc(8);
  endtask
  task automatic wait_en(input logic v);
    int k;
    k = 0;
    while (pattern_enable !== v && k < 20) begin
      cyc(1);
      k++;
    end
    chk("pattern_enable", {15'h0, v}, {15'h0, pattern_enable});
    if (k == 20) conclude();
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // =====
  // Sequence
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    conclude();
  end
  initial begin
    cyc(12);
    resetn = 1'b1;
    cyc(4);
    xfer(1'b1, 7'h03, 8'h00);
    chk("high reset", 16'h0000, {8'h00, rd});
    xfer(1'b1, 7'h04, 8'h00);
    chk("low reset", 16'h0000, {8'h00, rd});
    cda = 12'h5a3;
    cdb = 12'ha5c;
    cv = 1'b1;
    cyc(2);
    chk("word a", {2'b00, cda, 2'b00}, {2'b00, owa});
    chk("word b", {2'b00, cdb, 2'b00}, {2'b00, owb});
    chk("valid", 16'h0001, {15'h0, out_valid});
    // Stored pattern replaces both channel words
    for (int k = 0; k < 2; k++) begin
      xfer(1'b0, 7'h04, lo[k]);
      xfer(1'b0, 7'h03, hi[k]);
      wait_en(1'b1);
      cyc(2);
      chk("word a", {2'b00, hi[k][5:0], lo[k]}, {2'b00, owa});
      chk("word b", {2'b00, hi[k][5:0], lo[k]}, {2'b00, owb});
      xfer(1'b1, 7'h03, 8'h00);
      chk("high readback", {8'h00, hi[k] & 8'hbf}, {8'h00, rd});
      xfer(1'b1, 7'h04, 8'h00);
      chk("low readback", {8'h00, lo[k]}, {8'h00, rd});
    end
    ce = 1'b0;
    cda = 12'h123;
    cyc(3);
    chk("word a frozen", {2'b00, hi[1][5:0], lo[1]}, {2'b00, owa});
    ce = 1'b1;
    xfer(1'b0, 7'h03, 8'h00);
    wait_en(1'b0);
    cyc(2);
    chk("word a", {2'b00, cda, 2'b00}, {2'b00, owa});
    xfer(1'b0, 7'h05, 8'hff);
    xfer(1'b1, 7'h05, 8'h00);
    chk("unmapped", 16'h0000, {8'h00, rd});
    // An unmapped write must not alias onto the low register
    xfer(1'b1, 7'h04, 8'h00);
    chk("low after unmapped", {8'h00, lo[1]}, {8'h00, rd});
    conclude();
  end
endmodule

/* bench/tp_checker_asserts.sv */
// Purpose: Port checks for the test pattern bank
// Assumes: ce held high except short idle freezes
// Notes: Bound below the module
module tp_checker #(
  parameter int DATA_W = 12
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic [DATA_W-1:0] conv_data_a,
  input wire logic conv_valid,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire tp_pkg::out_word_t out_word_a,
  input wire tp_pkg::out_word_t out_word_b,
  input wire logic out_valid,
  input wire logic pattern_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  import tp_pkg::*;
  // =====
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Select released long enough for the sync chain
  sequence s_cs_idle;
    cs_n [*6];
  endsequence
  property p_pass;
    !pattern_enable && $past(ce) |-> out_word_a == {$past(conv_data_a), 2'b00};
  endproperty
  a_pass: assert property (p_pass) else $error("word not conversion");
  property p_valid;
    $past(ce) |-> out_valid == $past(conv_valid);
  endproperty
  a_valid: assert property (p_valid) else $error("valid misaligned");
  property p_same;
    pattern_enable |-> out_word_a == out_word_b;
  endproperty
  a_same: assert property (p_same) else $error("channels differ");
  property p_oe_cs;
    $rose(sdo_oe) |-> !cs_n;
  endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("drive without select");
  property p_sdo_idle;
    !sdo_oe |-> !sdo_out;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("sdo not low");
  property p_oe_release;
    s_cs_idle |-> !sdo_oe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("sdo held");
  property p_en_write;
    $changed(pattern_enable) |-> !sdo_oe;
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable moved in read");
  property p_freeze;
    !$past(ce) |-> $stable(out_word_a) && $stable(out_valid);
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved while frozen");
endmodule

bind output_test_pattern_regs tp_checker #(.DATA_W(DATA_W)) u_chk (
  .core_clk(core_clk), .resetn(resetn), .ce(ce), .cs_n(cs_n),
  .conv_data_a(conv_data_a), .conv_valid(conv_valid), .sdo_out(sdo_out),
  .sdo_oe(sdo_oe), .out_word_a(out_word_a), .out_word_b(out_word_b),
  .out_valid(out_valid), .pattern_enable(pattern_enable));

/* core/output_test_pattern_regs.sv */
// Purpose: Test pattern registers on the serial config port, and the data word mux for the serializers
// Assumes: Serial port pins are asynchronous; conversion words arrive on core_clk
// Notes: Pins are oversampled, so the serial clock must stay well below core_clk / 4
`include "tp_defines.svh"

module output_test_pattern_regs #(
  parameter int DATA_W = 12
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  output logic sdo_out,
  output logic sdo_oe,
  input wire logic [DATA_W-1:0] conv_data_a,
  input wire logic [DATA_W-1:0] conv_data_b,
  input wire logic conv_valid,
  output tp_pkg::out_word_t out_word_a,
  output tp_pkg::out_word_t out_word_b,
  output logic out_valid,
  output logic pattern_enable
);
  import tp_pkg::*;

  // =====================================================
  // Elaboration check: the register layout serves a 12-bit word only
  if (DATA_W != 12) begin : g_bad_width
    $error("output_test_pattern_regs supports DATA_W of 12 only");
  end

  // =====================================================
  // Pin synchronisers
  logic cs_n_s;
  logic sck_s;
  logic sdi_s;

  sync_2ff #(.RESET_VAL(1'b1)) u_sync_cs (
    .core_clk(core_clk),
    .resetn(resetn),
    .ce(ce),
    .async_in(cs_n),
    .sync_out(cs_n_s)
  );

  sync_2ff #(.RESET_VAL(1'b0)) u_sync_sck (
    .core_clk(core_clk),
    .resetn(resetn),
    .ce(ce),
    .async_in(sck),
    .sync_out(sck_s)
  );

  sync_2ff #(.RESET_VAL(1'b0)) u_sync_sdi (
    .core_clk(core_clk),
    .resetn(resetn),
    .ce(ce),
    .async_in(sdi),
    .sync_out(sdi_s)
  );

  // =====================================================
  // Serial port state
  spi_state_t state_r;
  spi_state_t state_nxt;
  logic sck_d_r;
  logic sck_d_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [6:0] shreg_r;
  logic [6:0] shreg_nxt;
  logic rd_r;
  logic rd_nxt;
  logic [6:0] addr_r;
  logic [6:0] addr_nxt;
  logic [7:0] rd_sh_r;
  logic [7:0] rd_sh_nxt;
  logic sdo_nxt;
  logic sdo_oe_nxt;
  reg_byte_t high_r;
  reg_byte_t high_nxt;
  reg_byte_t low_r;
  reg_byte_t low_nxt;
  logic sck_rise;
  logic sck_fall;
  logic [7:0] cmd_byte;
  reg_byte_t rd_val;

  // Edges seen on the synchronised serial clock
  assign sck_rise = sck_s & ~sck_d_r;
  assign sck_fall = ~sck_s & sck_d_r;
  assign cmd_byte = {shreg_r, sdi_s};

  // Read mux; unmapped offsets read as zero
  always_comb begin
    case (cmd_byte[6:0])
      `TP_ADDR_HIGH: rd_val = high_r;
      `TP_ADDR_LOW: rd_val = low_r;
      default: rd_val = 8'h00;
    endcase
  end

  // Frame decoder, register writes and read-back shifter
  always_comb begin
    state_nxt = state_r;
    sck_d_nxt = sck_s;
    cnt_nxt = cnt_r;
    shreg_nxt = shreg_r;
    rd_nxt = rd_r;
    addr_nxt = addr_r;
    rd_sh_nxt = rd_sh_r;
    sdo_nxt = sdo_out;
    sdo_oe_nxt = sdo_oe;
    high_nxt = high_r;
    low_nxt = low_r;
    if (cs_n_s) begin
      // Deselect aborts any partial frame, so a torn write never lands
      state_nxt = ST_IDLE;
      sdo_oe_nxt = 1'b0;
      sdo_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          state_nxt = ST_CMD;
          cnt_nxt = 5'h00;
        end
        ST_CMD: begin
          if (sck_rise) begin
            shreg_nxt = cmd_byte[6:0];
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == `SPI_CMD_LAST) begin
              state_nxt = ST_DATA;
              rd_nxt = cmd_byte[7];
              addr_nxt = cmd_byte[6:0];
              rd_sh_nxt = rd_val;
              sdo_oe_nxt = cmd_byte[7];
            end
          end
        end
        ST_DATA: begin
          // Read data leaves on falling edges, ready for the next rising edge
          if (sck_fall && rd_r) begin
            sdo_nxt = rd_sh_r[7];
            rd_sh_nxt = {rd_sh_r[6:0], 1'b0};
          end
          if (sck_rise) begin
            shreg_nxt = cmd_byte[6:0];
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == `SPI_FRAME_LAST) begin
              state_nxt = ST_DONE;
              if (!rd_r && addr_r == `TP_ADDR_HIGH) begin
                high_nxt[`TP_EN_BIT] = cmd_byte[`TP_EN_BIT];
                high_nxt[`TP_UNUSED_BIT] = 1'b0;
                high_nxt[`TP_HIGH_DATA_MSB:0] = cmd_byte[`TP_HIGH_DATA_MSB:0];
              end
              if (!rd_r && addr_r == `TP_ADDR_LOW) begin
                low_nxt = cmd_byte;
              end
            end
          end
        end
        ST_DONE: begin
          // Extra clocks past the frame are ignored until deselect
          state_nxt = ST_DONE;
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // Serial port registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      sck_d_r <= 1'b0;
      cnt_r <= 5'h00;
      shreg_r <= 7'h00;
      rd_r <= 1'b0;
      addr_r <= 7'h00;
      rd_sh_r <= 8'h00;
      sdo_out <= 1'b0;
      sdo_oe <= 1'b0;
      high_r <= `TP_HIGH_RST;
      low_r <= `TP_LOW_RST;
    end else if (ce) begin
      state_r <= state_nxt;
      sck_d_r <= sck_d_nxt;
      cnt_r <= cnt_nxt;
      shreg_r <= shreg_nxt;
      rd_r <= rd_nxt;
      addr_r <= addr_nxt;
      rd_sh_r <= rd_sh_nxt;
      sdo_out <= sdo_nxt;
      sdo_oe <= sdo_oe_nxt;
      high_r <= high_nxt;
      low_r <= low_nxt;
    end
  end

  // =====================================================
  // Output word mux toward the channel serializers
  out_word_t pattern_word;
  out_word_t word_a_nxt;
  out_word_t word_b_nxt;
  logic valid_nxt;
  logic en_nxt;

  // pattern assembly, in 14-bit layout with extras last
  assign pattern_word = {high_r[`TP_HIGH_DATA_MSB:0], low_r[7:`TP_LOW_DATA_LSB],
                         low_r[`TP_EXTRA_A_BIT], low_r[`TP_EXTRA_B_BIT]};

  always_comb begin
    en_nxt = high_r[`TP_EN_BIT];
    word_a_nxt = en_nxt ? pattern_word : {conv_data_a, 2'b00};
    word_b_nxt = en_nxt ? pattern_word : {conv_data_b, 2'b00};
    valid_nxt = conv_valid;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      out_word_a <= 14'h0000;
      out_word_b <= 14'h0000;
      out_valid <= 1'b0;
      pattern_enable <= 1'b0;
    end else if (ce) begin
      out_word_a <= word_a_nxt;
      out_word_b <= word_b_nxt;
      out_valid <= valid_nxt;
      pattern_enable <= en_nxt;
    end
  end

endmodule

/* core/sync_2ff.sv */
// Purpose: Two flip-flop synchroniser for one pin level
// Assumes: Input is asynchronous to core_clk
// Notes: First stage feeds only the second stage
module sync_2ff #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_r;
  logic meta_nxt;
  logic sync_nxt;

  // =====================================================
  // Next values: hold while the clock enable is low
  always_comb begin
    meta_nxt = ce ? async_in : meta_r;
    sync_nxt = ce ? meta_r : sync_out;
  end

  // Registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_r <= meta_nxt;
      sync_out <= sync_nxt;
    end
  end

endmodule

/* shared/tp_defines.svh */
// Purpose: Offsets, field positions, reset values and frame counts of the test pattern registers
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef TP_DEFINES_SVH
`define TP_DEFINES_SVH

// =====================================================
// Register offsets on the serial configuration port
`define TP_ADDR_HIGH 7'h03
`define TP_ADDR_LOW 7'h04

// =====================================================
// Field positions
`define TP_EN_BIT 7
`define TP_UNUSED_BIT 6
`define TP_HIGH_DATA_MSB 5
`define TP_LOW_DATA_LSB 2
`define TP_EXTRA_A_BIT 1
`define TP_EXTRA_B_BIT 0

// =====================================================
// Reset values
`define TP_HIGH_RST 8'h00
`define TP_LOW_RST 8'h00

// =====================================================
// Serial frame: read/write flag, 7-bit address, 8-bit data
`define SPI_CMD_LAST 5'h07
`define SPI_FRAME_LAST 5'h0f

`endif

/* shared/tp_pkg.sv */
// Purpose: Types shared by the test pattern register bank
// Assumes: Nothing
// Notes: Constants live in tp_defines.svh
package tp_pkg;

  // =====================================================
  // Types
  typedef logic [7:0] reg_byte_t;
  typedef logic [13:0] out_word_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CMD = 4'h2,
    ST_DATA = 4'h4,
    ST_DONE = 4'h8
  } spi_state_t;

endpackage
